// *** rtl/dac_control_register_bank.v ***
// Summary of operation
// - Writing zero to no-operation changes nothing
// - Identity reads fixed part and revision codes
// - Status bit 1 shows converter not ready
// - Over-temperature sets bit 0, powers output down
// - Status resets zero, read-only, upper reserved
// - Serial config resets 0aa4, only listed bits writable
// - Read data returns in the following frame
// - Checksum failure discards write, sets alarm
// - Serial config bit 1 picks output edge
`timescale 1ns/1ns
`include "dac_regs_defines.vh"
module dac_control_register_bank #(
  // Arbitrary identity values
  parameter [13:0] PART_ID = 14'h0123,
  parameter [1:0] REVISION_CODE = 2'h0
) (
  input wire mclk,
  input wire rstn,
  input wire sclk,
  input wire sync_n,
  input wire sdi,
  input wire over_temp,
  input wire update_busy,
  output reg sdo_r,
  output reg sdo_oe_r,
  output reg fault_n_r,
  output reg [15:0] output_code_r,
  output reg output_load_r,
  output reg [3:0] output_range_select_r,
  output reg output_hold_off_r,
  output reg reference_off_r,
  output reg device_sleep_r
);

reg [15:0] serial_config_r;
reg [15:0] general_config_r;
reg output_off_r;
reg checksum_alarm_r;
reg over_temperature_alarm_r;
reg busy_r;
reg [31:0] rx_r;
reg [31:0] tx_r;
reg [5:0] bit_cnt_r;
reg [23:0] resp_r;
reg [23:0] resp_nxt;
reg [5:0] need_bits;
reg [23:0] frame;
reg crc_ok;
reg wr_ok;
reg alarm_clear;
wire sclk_rise;
wire sclk_fall;
wire frame_start;
wire frame_end;
wire crc_en;
wire shift_out;

function [7:0] crc8_24;
  input [23:0] d;
  integer i;
  reg [7:0] c;
  begin
    c = 8'h00;
    for (i = 23; i >= 0; i = i - 1) begin
      if (c[7] ^ d[i])
        c = {c[6:0], 1'b0} ^ `CRC8_POLY;
      else
        c = {c[6:0], 1'b0};
    end
    crc8_24 = c;
  end
endfunction

function [15:0] read_mux;
  input [5:0] a;
  input [15:0] sc;
  input [15:0] gc;
  input pd;
  input [2:0] st;
  begin
    case (a)
      `ADDR_PART_IDENTITY: read_mux = {PART_ID, REVISION_CODE};
      `ADDR_ALARM_FLAGS: read_mux = {13'h0000, st};
      `ADDR_SERIAL_CONFIG: read_mux = sc;
      `ADDR_GENERAL_CONFIG: read_mux = gc;
      `ADDR_OUTPUT_POWER_DOWN: read_mux = {15'h7fff, pd};
      default: read_mux = `RST_ZERO;
    endcase
  end
endfunction

serial_edges u_edges (
  .mclk(mclk),
  .rstn(rstn),
  .sclk(sclk),
  .sync_n(sync_n),
  .sclk_rise_r(sclk_rise),
  .sclk_fall_r(sclk_fall),
  .frame_start_r(frame_start),
  .frame_end_r(frame_end)
);

assign crc_en = serial_config_r[`SC_CHECKSUM_EN];
// Output edge chosen by the fast-edge bit
assign shift_out = serial_config_r[`SC_FAST_OUT_EDGE] ? sclk_fall :
                   sclk_rise;

always @* begin
  need_bits = crc_en ? `FRAME_BITS_CHECKED : `FRAME_BITS_PLAIN;
  frame = crc_en ? rx_r[31:8] : rx_r[23:0];
  crc_ok = ~crc_en | (crc8_24(rx_r[31:8]) == rx_r[7:0]);
  // Short frames are dropped; long ones keep their last bits
  wr_ok = frame_end & (bit_cnt_r >= need_bits) & crc_ok & ~frame[23];
  alarm_clear = wr_ok & (frame[21:16] == `ADDR_ACTION_TRIGGER) &
                frame[`TRG_ALARM_CLEAR];
  resp_nxt = {frame[23], ~crc_ok, frame[21:16],
              frame[23] ? read_mux(frame[21:16], serial_config_r,
                                   general_config_r, output_off_r,
                                   {checksum_alarm_r, busy_r,
                                    over_temperature_alarm_r})
                        : frame[15:0]};
end

always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    rx_r <= 32'h00000000;
    bit_cnt_r <= 6'd0;
  end else if (frame_start) begin
    bit_cnt_r <= 6'd0;
  end else if (sclk_fall) begin
    rx_r <= {rx_r[30:0], sdi};
    if (bit_cnt_r != 6'h3f)
      bit_cnt_r <= bit_cnt_r + 6'd1;
  end
end

// Response captured at frame end, shifted out in the next frame
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    resp_r <= 24'h000000;
    tx_r <= 32'h00000000;
    sdo_r <= 1'b0;
    sdo_oe_r <= 1'b0;
  end else begin
    if (frame_end && bit_cnt_r >= need_bits)
      resp_r <= resp_nxt;
    if (frame_start) begin
      tx_r <= crc_en ? {resp_r, crc8_24(resp_r)} : {resp_r, 8'h00};
      sdo_r <= resp_r[23];
    end else if (shift_out) begin
      // Daisy chain: incoming bits ripple out behind the response
      tx_r <= {tx_r[30:0], sdi};
      sdo_r <= tx_r[30];
    end
    sdo_oe_r <= ~sync_n & serial_config_r[`SC_SERIAL_OUT_EN];
  end
end

always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    serial_config_r <= `RST_SERIAL_CONFIG;
    general_config_r <= `RST_GENERAL_CONFIG;
    // Only bit 0 of the power-down word is stored; it resets high
    output_off_r <= 1'b1;
    output_range_select_r <= 4'h0;
    output_code_r <= `RST_ZERO;
    output_load_r <= 1'b0;
  end else begin
    output_load_r <= 1'b0;
    // Zero to no-operation and writes to read-only space fall through
    if (wr_ok) begin
      case (frame[21:16])
        `ADDR_SERIAL_CONFIG:
          serial_config_r <= (frame[15:0] & `WMASK_SERIAL_CONFIG) |
            (`RST_SERIAL_CONFIG & ~`WMASK_SERIAL_CONFIG);
        `ADDR_GENERAL_CONFIG:
          general_config_r <= frame[15:0] & `WMASK_GENERAL_CONFIG;
        `ADDR_OUTPUT_POWER_DOWN:
          output_off_r <= frame[0];
        `ADDR_OUTPUT_RANGE_SELECT:
          output_range_select_r <= frame[3:0];
        `ADDR_ACTION_TRIGGER: begin
          if (frame[`TRG_SOFTWARE_CLEAR]) begin
            output_code_r <= `RST_ZERO;
            output_load_r <= 1'b1;
          end
        end
        `ADDR_OUTPUT_CODE: begin
          output_code_r <= frame[15:0];
          output_load_r <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end
end

// Flags set by events only; a set beats a simultaneous clear
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    checksum_alarm_r <= 1'b0;
    over_temperature_alarm_r <= 1'b0;
    busy_r <= 1'b0;
  end else begin
    busy_r <= update_busy;
    if (frame_end && bit_cnt_r >= need_bits && !crc_ok)
      checksum_alarm_r <= 1'b1;
    else if (alarm_clear)
      checksum_alarm_r <= 1'b0;
    if (over_temp)
      over_temperature_alarm_r <= 1'b1;
    else if (alarm_clear)
      over_temperature_alarm_r <= 1'b0;
  end
end

always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    fault_n_r <= 1'b1;
    output_hold_off_r <= 1'b1;
    reference_off_r <= 1'b1;
    device_sleep_r <= 1'b1;
  end else begin
    fault_n_r <= ~((over_temperature_alarm_r &
                    serial_config_r[`SC_THERMAL_FAULT_EN]) |
                   (busy_r &
                    serial_config_r[`SC_UPDATE_PENDING_FAULT_EN]) |
                   (checksum_alarm_r &
                    serial_config_r[`SC_CHECKSUM_FAULT_EN]));
    output_hold_off_r <= output_off_r | over_temperature_alarm_r;
    reference_off_r <= general_config_r[`GC_REFERENCE_OFF];
    device_sleep_r <= serial_config_r[`SC_DEVICE_SLEEP];
  end
end

endmodule // dac_control_register_bank

// *** rtl/dac_regs_defines.vh ***
`ifndef DAC_REGS_DEFINES_VH
`define DAC_REGS_DEFINES_VH

`define ADDR_NO_OPERATION 6'h00
`define ADDR_PART_IDENTITY 6'h01
`define ADDR_ALARM_FLAGS 6'h02
`define ADDR_SERIAL_CONFIG 6'h03
`define ADDR_GENERAL_CONFIG 6'h04
`define ADDR_OUTPUT_POWER_DOWN 6'h09
`define ADDR_OUTPUT_RANGE_SELECT 6'h0a
`define ADDR_ACTION_TRIGGER 6'h0e
`define ADDR_OUTPUT_CODE 6'h10

`define RST_SERIAL_CONFIG 16'h0aa4
`define RST_GENERAL_CONFIG 16'h4000
`define RST_OUTPUT_POWER_DOWN 16'hffff
`define RST_ZERO 16'h0000

`define WMASK_SERIAL_CONFIG 16'h0e36
`define WMASK_GENERAL_CONFIG 16'h4000
`define WMASK_OUTPUT_POWER_DOWN 16'h0001
`define WMASK_OUTPUT_RANGE_SELECT 16'h000f

`define SC_THERMAL_FAULT_EN 11
`define SC_UPDATE_PENDING_FAULT_EN 10
`define SC_CHECKSUM_FAULT_EN 9
`define SC_DEVICE_SLEEP 5
`define SC_CHECKSUM_EN 4
`define SC_SERIAL_OUT_EN 2
`define SC_FAST_OUT_EDGE 1

`define GC_REFERENCE_OFF 14
`define TRG_SOFTWARE_CLEAR 9
`define TRG_ALARM_CLEAR 8

`define ST_CHECKSUM_ALARM 2
`define ST_UPDATE_BUSY 1
`define ST_OVER_TEMP_ALARM 0

`define FRAME_BITS_PLAIN 6'd24
`define FRAME_BITS_CHECKED 6'd32
`define CRC8_POLY 8'h07

`endif

// *** rtl/serial_edges.v ***
`timescale 1ns/1ns
module serial_edges (
  input wire mclk,
  input wire rstn,
  input wire sclk,
  input wire sync_n,
  output reg sclk_rise_r,
  output reg sclk_fall_r,
  output reg frame_start_r,
  output reg frame_end_r
);

reg sclk_d_r;
reg sync_n_d_r;

always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    sclk_d_r <= 1'b0;
    sync_n_d_r <= 1'b1;
    sclk_rise_r <= 1'b0;
    sclk_fall_r <= 1'b0;
    frame_start_r <= 1'b0;
    frame_end_r <= 1'b0;
  end else begin
    sclk_d_r <= sclk;
    sync_n_d_r <= sync_n;
    sclk_rise_r <= sclk & ~sclk_d_r & ~sync_n;
    sclk_fall_r <= ~sclk & sclk_d_r & ~sync_n;
    frame_start_r <= sync_n_d_r & ~sync_n;
    frame_end_r <= ~sync_n_d_r & sync_n;
  end
end

endmodule // serial_edges

// *** verification/dac_bank_props.sv ***
`timescale 1ns/1ns
module dac_bank_props (
  input wire mclk,
  input wire rstn,
  input wire sclk,
  input wire sync_n,
  input wire over_temp,
  input wire sdo_r,
  input wire sdo_oe_r,
  input wire [15:0] output_code_r,
  input wire output_load_r,
  input wire [3:0] output_range_select_r,
  input wire output_hold_off_r,
  input wire reference_off_r,
  input wire device_sleep_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Writes land only after the frame closes
  sequence s_frame;
    (!sync_n) [*5];
  endsequence
  property p_rst;
    $rose(rstn) |-> device_sleep_r && reference_off_r && output_hold_off_r;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  property p_oe;
    sync_n [*3] |-> !sdo_oe_r;
  endproperty
  a_oe: assert property (p_oe) else $error("sdo driven idle");
  property p_code;
    s_frame |-> $stable(output_code_r) && $stable(output_range_select_r);
  endproperty
  a_code: assert property (p_code) else $error("code mid frame");
  property p_cfg;
    s_frame |-> $stable(device_sleep_r) && $stable(reference_off_r);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config mid frame");
  property p_ld;
    s_frame |-> !output_load_r;
  endproperty
  a_ld: assert property (p_ld) else $error("load mid frame");
  property p_chg;
    $changed(output_code_r) |-> output_load_r || $past(output_load_r);
  endproperty
  a_chg: assert property (p_chg) else $error("code without load");
  property p_hot;
    over_temp [*2] |-> ##[0:2] output_hold_off_r;
  endproperty
  a_hot: assert property (p_hot) else $error("hot output on");
  property p_sdo;
    sdo_oe_r && $past(sdo_oe_r, 4) && $changed(sdo_r)
      |-> $past(sclk, 1) != $past(sclk, 4);
  endproperty
  a_sdo: assert property (p_sdo) else $error("sdo moved off edge");
endmodule // dac_bank_props

bind dac_control_register_bank dac_bank_props u_dac_bank_props (
  .mclk(mclk), .rstn(rstn), .sclk(sclk), .sync_n(sync_n),
  .over_temp(over_temp), .sdo_r(sdo_r), .sdo_oe_r(sdo_oe_r),
  .output_code_r(output_code_r), .output_load_r(output_load_r),
  .output_range_select_r(output_range_select_r),
  .output_hold_off_r(output_hold_off_r),
  .reference_off_r(reference_off_r), .device_sleep_r(device_sleep_r)
);

// *** verification/serial_host.sv ***
`timescale 1ns/1ns
module serial_host (
  input wire mclk,
  input wire sdo_r,
  input wire sdo_oe_r,
  output reg sclk,
  output reg sync_n,
  output reg sdi
);
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdi = 1'b0;
  end
  // Callers use listed offsets, plus one read of unlisted offset 05
  task xfer(input [31:0] tx, input integer n, output [31:0] rx);
    integer i;
    begin
      rx = 32'h0;
      @(posedge mclk) #1 sync_n = 1'b0;
      repeat (4) @(posedge mclk);
      for (i = n - 1; i >= 0; i = i - 1) begin
        // A released output line reads back inverted
        #1 rx[i] = sdo_oe_r ? sdo_r : ~sdo_r;
        sclk = 1'b1;
        sdi = tx[i];
        repeat (4) @(posedge mclk);
        #1 sclk = 1'b0;
        repeat (4) @(posedge mclk);
      end
      #1 sync_n = 1'b1;
      // Released line must not look driven
      sdi = ~sdi;
      repeat (6) @(posedge mclk);
    end
  endtask
endmodule // serial_host

// *** verification/dac_control_register_bank_test.sv ***
`timescale 1ns/1ns
module dac_control_register_bank_test;
  localparam [13:0] PART_ID = 14'h0123; // Arbitrary
  localparam [1:0] REV = 2'h2; // Arbitrary
  reg mclk, rstn, over_temp, update_busy, crc_on;
  reg [23:0] r;
  integer fail_count, n_checks, cyc;
  wire sclk, sync_n, sdi, sdo_r, sdo_oe_r, fault_n_r, output_load_r;
  wire output_hold_off_r, reference_off_r, device_sleep_r;
  wire [15:0] output_code_r;
  wire [3:0] output_range_select_r;
  dac_control_register_bank #(.PART_ID(PART_ID), .REVISION_CODE(REV))
    u_dac_control_register_bank (.mclk(mclk), .rstn(rstn), .sclk(sclk),
    .sync_n(sync_n), .sdi(sdi), .over_temp(over_temp),
    .update_busy(update_busy), .sdo_r(sdo_r), .sdo_oe_r(sdo_oe_r),
    .fault_n_r(fault_n_r), .output_code_r(output_code_r),
    .output_load_r(output_load_r),
    .output_range_select_r(output_range_select_r),
    .output_hold_off_r(output_hold_off_r),
    .reference_off_r(reference_off_r), .device_sleep_r(device_sleep_r));
  serial_host u_serial_host (.mclk(mclk), .sdo_r(sdo_r),
    .sdo_oe_r(sdo_oe_r), .sclk(sclk), .sync_n(sync_n), .sdi(sdi));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      end_sim;
    end
  end
  task chk_word(input [23:0] got, input [23:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task chk_bit(input got, input exp);
    chk_word({23'h0, got}, {23'h0, exp});
  endtask
  function [7:0] crc8(input [23:0] d);
    integer i;
    begin
      crc8 = 8'h00;
      for (i = 23; i >= 0; i = i - 1)
        crc8 = {crc8[6:0], 1'b0} ^ ((crc8[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
  endfunction
  task frame(input [23:0] w, input [7:0] bad);
    reg [31:0] rx;
    begin
      if (crc_on) begin
        u_serial_host.xfer({w, crc8(w) ^ bad}, 32, rx);
        chk_word({16'h0, rx[7:0]}, {16'h0, crc8(rx[31:8])});
      end else
        u_serial_host.xfer({8'h00, w}, 24, rx);
      r = crc_on ? rx[31:8] : rx[23:0];
    end
  endtask
  task wr(input [5:0] a, input [15:0] d);
    frame({2'b00, a, d}, 8'h00);
  endtask
  task rd(input [5:0] a, input [15:0] exp);
    begin
      frame({2'b10, a, 16'h0000}, 8'h00);
      frame(24'h000000, 8'h00);
      chk_word(r, {2'b10, a, exp});
    end
  endtask
  task pins(input hot, input busy);
    begin
      @(posedge mclk) #1 over_temp = hot;
      update_busy = busy;
      repeat (8) @(posedge mclk);
    end
  endtask
  initial begin
    {rstn, over_temp, update_busy, crc_on} = 4'h0;
    {fail_count, n_checks, cyc} = 0;
    repeat (5) @(posedge mclk);
    #1 rstn = 1'b1;
    repeat (2) @(posedge mclk);
    rd(6'h01, {PART_ID, REV});
    rd(6'h02, 16'h0000);
    rd(6'h03, 16'h0aa4);
    rd(6'h04, 16'h4000);
    rd(6'h09, 16'hffff);
    wr(6'h01, 16'hffff);
    wr(6'h02, 16'hffff);
    rd(6'h01, {PART_ID, REV});
    rd(6'h02, 16'h0000);
    frame(24'h850000, 8'h00);
    frame(24'h000000, 8'h00);
    chk_word({r[23:16], 16'h0}, 24'h850000);
    wr(6'h03, 16'hffed);
    rd(6'h03, 16'h0ea4);
    pins(1'b0, 1'b1);
    chk_bit(fault_n_r, 1'b0);
    rd(6'h02, 16'h0002);
    pins(1'b0, 1'b0);
    chk_bit(fault_n_r, 1'b1);
    wr(6'h03, 16'h0006);
    rd(6'h03, 16'h0086);
    chk_bit(device_sleep_r, 1'b0);
    wr(6'h04, 16'h0000);
    chk_bit(reference_off_r, 1'b0);
    wr(6'h09, 16'h0000);
    rd(6'h09, 16'hfffe);
    chk_bit(output_hold_off_r, 1'b0);
    wr(6'h0a, 16'hfff5);
    chk_word(output_range_select_r, 24'h5);
    rd(6'h0a, 16'h0000);
    wr(6'h10, 16'h1234);
    chk_word(output_code_r, 24'h1234);
    pins(1'b1, 1'b0);
    pins(1'b0, 1'b0);
    chk_bit(output_hold_off_r, 1'b1);
    rd(6'h02, 16'h0001);
    wr(6'h0e, 16'h0100);
    rd(6'h02, 16'h0000);
    wr(6'h03, 16'h0016);
    crc_on = 1'b1;
    frame({2'b00, 6'h10, 16'h5555}, 8'h01);
    chk_word(output_code_r, 24'h1234);
    frame(24'h000000, 8'h00);
    chk_word(r, {2'b01, 6'h10, 16'h5555});
    rd(6'h02, 16'h0004);
    wr(6'h0e, 16'h0200);
    chk_word(output_code_r, 24'h0);
    #1 rstn = 1'b0;
    repeat (5) @(posedge mclk);
    #1 rstn = 1'b1;
    crc_on = 1'b0;
    repeat (2) @(posedge mclk);
    rd(6'h03, 16'h0aa4);
    end_sim;
  end
endmodule // dac_control_register_bank_test
